// >>> rtl/acp_consts.vh
/*
 * Shared constants of the ASCII channel command parser: character codes,
 * channel numbers, field widths, state and field codes, decimal weights.
 * Assumes inclusion by bare name from the parser and its buffer.
 */
`ifndef ACP_CONSTS_VH
`define ACP_CONSTS_VH

// Character codes seen on the serial stream.
`define ACP_CR 8'h0d
`define ACP_COMMA 8'h2c
`define ACP_STAR 8'h2a
`define ACP_SEMI 8'h3b
`define ACP_ZERO 8'h30
`define ACP_NINE 8'h39
`define ACP_LET_H 8'h68
`define ACP_LET_C 8'h63

// Channel numbers with a special meaning.
`define ACP_BCAST_CHAN 8'h00
`define ACP_CFG_CHAN 8'h63
`define ACP_FIRST_CHAN 8'h01
`define ACP_NCH_W 8'h02
`define ACP_NCH 2
`define ACP_CIW 1

// Field widths.
`define ACP_BYTE_W 8
`define ACP_VAL_W 16
`define ACP_FNO_W 8

// Reset values.
`define ACP_MODE_RST 1'b1
`define ACP_CHAN_RST 8'h01

// Top level states.
`define ACP_S_PARSE 3'h0
`define ACP_S_DISP 3'h1
`define ACP_S_WAIT 3'h2
`define ACP_S_FIELD 3'h3
`define ACP_S_NUM 3'h4

// Parse phases.
`define ACP_PH_CHAN 2'h0
`define ACP_PH_WAIT 2'h1
`define ACP_PH_ARG 2'h2

// Response field walk.
`define ACP_F_CHAN 3'h0
`define ACP_F_LET 3'h1
`define ACP_F_V1 3'h2
`define ACP_F_V2 3'h3
`define ACP_F_V3 3'h4
`define ACP_F_FLT 3'h5
`define ACP_F_TERM 3'h6

// Decimal weights for the number printer.
`define ACP_POW0 16'h2710
`define ACP_POW1 16'h03e8
`define ACP_POW2 16'h0064
`define ACP_POW3 16'h000a
`define ACP_POW4 16'h0001
`define ACP_PW_LAST 3'h4
`define ACP_TEN8 8'h0a
`define ACP_TEN16 16'h000a
`define ACP_CNT_FULL 2'h3
`define ACP_ARG_LAST 2'h2

`endif

// >>> rtl/acp_buf2.v
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset shared with the parser.
 */
`timescale 1ns/1ns
`include "acp_consts.vh"

module acp_buf2 (
    input wire mclk_in,
    input wire resetn_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [`ACP_BYTE_W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [`ACP_BYTE_W-1:0] out_data_out
);

    reg [`ACP_BYTE_W-1:0] head_q;
    reg [`ACP_BYTE_W-1:0] tail_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;

    // Ready drops only when both slots hold a word, so a stall loses nothing.
    assign in_ready_out = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out = head_q;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Head is the word on the output; tail holds the second word.
    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            head_q <= 8'h00;
            tail_q <= 8'h00;
            cnt_q <= 2'h0;
        end else begin
            if (pop) begin
                head_q <= (cnt_q == 2'h2) ? tail_q : in_data_in;
            end else if (push && cnt_q == 2'h0) begin
                head_q <= in_data_in;
            end
            if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2)) begin
                tail_q <= in_data_in;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

endmodule // acp_buf2

// >>> rtl/acp_parser.v
/*
 * ASCII channel command parser: splits carriage-return terminated commands
 * into channel, letter and up to three decimal arguments, dispatches them to
 * the channels one at a time and formats the echo-style response.
 * Assumes the receive bytes and the channel answers come from logic on the
 * same clock, and that the host waits for the closing carriage return.
 */
`timescale 1ns/1ns
`include "acp_consts.vh"

module acp_parser (
    input wire mclk_in,
    input wire resetn_in,
    input wire rx_valid_in,
    input wire [`ACP_BYTE_W-1:0] rx_data_in,
    output wire rx_ready_out,
    output wire tx_valid_out,
    output wire [`ACP_BYTE_W-1:0] tx_data_out,
    input wire tx_ready_in,
    output wire cmd_valid_out,
    output reg [`ACP_BYTE_W-1:0] cmd_chan_out,
    output reg [`ACP_BYTE_W-1:0] cmd_letter_out,
    output reg [`ACP_VAL_W-1:0] cmd_arg1_out,
    output reg [`ACP_VAL_W-1:0] cmd_arg2_out,
    output reg [`ACP_VAL_W-1:0] cmd_arg3_out,
    output reg [1:0] cmd_nargs_out,
    input wire resp_valid_in,
    input wire [1:0] resp_count_in,
    input wire [`ACP_VAL_W-1:0] resp_val1_in,
    input wire [`ACP_VAL_W-1:0] resp_val2_in,
    input wire [`ACP_VAL_W-1:0] resp_val3_in,
    input wire [`ACP_NCH-1:0] fault_set_in,
    input wire [`ACP_NCH*`ACP_FNO_W-1:0] fault_no_in,
    output reg [`ACP_NCH-1:0] fault_active_out,
    output reg verbose_out
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    reg [2:0] state_q;
    reg [1:0] ph_q;
    reg [`ACP_BYTE_W-1:0] chan_acc_q;
    reg chan_seen_q;
    reg [1:0] aidx_q;
    reg [`ACP_BYTE_W-1:0] chan_q;
    reg last_q;
    reg cfg_q;
    reg [`ACP_VAL_W-1:0] rv_q [0:2];
    reg [1:0] rcnt_q;
    reg rflt_q;
    reg [`ACP_FNO_W-1:0] rfno_q;
    reg [`ACP_FNO_W-1:0] fno_q [0:`ACP_NCH-1];
    reg [2:0] f_q;
    reg [`ACP_VAL_W-1:0] num_q;
    reg [2:0] pw_q;
    reg [3:0] dig_q;
    reg nz_q;
    reg pend_q;
    reg [`ACP_BYTE_W-1:0] pchar_q;
    wire buf_ready;
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Character decode and digit accumulation.

    // Any byte outside the digit range, backspace included, is just a non-digit.
    wire rx_take = rx_valid_in && rx_ready_out;
    wire is_dig = (rx_data_in >= `ACP_ZERO) && (rx_data_in <= `ACP_NINE);
    wire is_cr = (rx_data_in == `ACP_CR);
    wire [`ACP_BYTE_W-1:0] dsub = rx_data_in - `ACP_ZERO;
    wire [3:0] dval = dsub[3:0];
    // Values wrap silently above their field width; no overflow flag exists.
    wire [`ACP_BYTE_W-1:0] chan_nx = chan_acc_q * `ACP_TEN8 + {4'h0, dval};
    reg [`ACP_VAL_W-1:0] arg_cur;
    always @* begin
        case (aidx_q)
            2'h0: arg_cur = cmd_arg1_out;
            2'h1: arg_cur = cmd_arg2_out;
            default: arg_cur = cmd_arg3_out;
        endcase
    end
    wire [`ACP_VAL_W-1:0] arg_nx = arg_cur * `ACP_TEN16 + {12'h000, dval};
    // Target after the return: a missing channel keeps the one before.
    wire [`ACP_BYTE_W-1:0] tgt = chan_seen_q ? chan_acc_q : chan_q;
    wire [`ACP_BYTE_W-1:0] ci_full = cmd_chan_out - `ACP_FIRST_CHAN;
    wire [`ACP_CIW-1:0] ci = ci_full[`ACP_CIW-1:0];
    wire clr_ev = (state_q == `ACP_S_WAIT) && resp_valid_in && (cmd_letter_out == `ACP_LET_C);
    // A third value gives way to the fault number.
    wire [1:0] ceff = (rflt_q && rcnt_q == `ACP_CNT_FULL) ? 2'h2 : rcnt_q;
    wire [2:0] fk_full = f_q - `ACP_F_V1;
    wire [1:0] fk = fk_full[1:0];

    // Weight of the digit now being printed.
    reg [`ACP_VAL_W-1:0] pow;
    always @* begin
        case (pw_q)
            3'h0: pow = `ACP_POW0;
            3'h1: pow = `ACP_POW1;
            3'h2: pow = `ACP_POW2;
            3'h3: pow = `ACP_POW3;
            default: pow = `ACP_POW4;
        endcase
    end

    // Bytes are taken only while parsing with no character waiting to go out.
    assign rx_ready_out = (state_q == `ACP_S_PARSE) && !pend_q;
    assign cmd_valid_out = (state_q == `ACP_S_DISP);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel fault latches; a new fault beats a clear in the same cycle.

    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_active_out <= {`ACP_NCH{1'b0}};
            for (i = 0; i < `ACP_NCH; i = i + 1) begin
                fno_q[i] <= 8'h00;
            end
        end else begin
            for (i = 0; i < `ACP_NCH; i = i + 1) begin
                if (fault_set_in[i]) begin
                    fault_active_out[i] <= 1'b1;
                    fno_q[i] <= fault_no_in[i*`ACP_FNO_W +: `ACP_FNO_W];
                end else if (clr_ev && ci == i) begin
                    fault_active_out[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer: parse, dispatch, collect, format.

    // The output character register gets receive data only through the stored letter, so typed bytes do not echo.
    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= `ACP_S_PARSE;
            ph_q <= `ACP_PH_CHAN;
            chan_acc_q <= 8'h00;
            chan_seen_q <= 1'b0;
            aidx_q <= 2'h0;
            chan_q <= `ACP_CHAN_RST;
            last_q <= 1'b1;
            cfg_q <= 1'b0;
            rv_q[0] <= 16'h0000;
            rv_q[1] <= 16'h0000;
            rv_q[2] <= 16'h0000;
            rcnt_q <= 2'h0;
            rflt_q <= 1'b0;
            rfno_q <= 8'h00;
            f_q <= `ACP_F_CHAN;
            num_q <= 16'h0000;
            pw_q <= 3'h0;
            dig_q <= 4'h0;
            nz_q <= 1'b0;
            pend_q <= 1'b0;
            pchar_q <= 8'h00;
            cmd_chan_out <= 8'h00;
            cmd_letter_out <= 8'h00;
            cmd_arg1_out <= 16'h0000;
            cmd_arg2_out <= 16'h0000;
            cmd_arg3_out <= 16'h0000;
            cmd_nargs_out <= 2'h0;
            verbose_out <= `ACP_MODE_RST;
        end else begin
            if (pend_q && buf_ready) begin
                pend_q <= 1'b0;
            end
            case (state_q)
                `ACP_S_PARSE: begin
                    if (rx_take && is_cr) begin
                        ph_q <= `ACP_PH_CHAN;
                        chan_acc_q <= 8'h00;
                        chan_seen_q <= 1'b0;
                        aidx_q <= 2'h0;
                        chan_q <= tgt;
                        f_q <= `ACP_F_CHAN;
                        cfg_q <= 1'b0;
                        if (tgt == `ACP_CFG_CHAN) begin
                            // The mode command answers with its own setting.
                            cfg_q <= 1'b1;
                            last_q <= 1'b1;
                            rflt_q <= 1'b0;
                            rcnt_q <= 2'h0;
                            if (cmd_letter_out == `ACP_LET_H) begin
                                rcnt_q <= 2'h1;
                                rv_q[0] <= {15'h0000, verbose_out};
                                if (cmd_nargs_out != 2'h0) begin
                                    verbose_out <= (cmd_arg1_out != 16'h0000);
                                    rv_q[0] <= {15'h0000, (cmd_arg1_out != 16'h0000)};
                                end
                            end
                            state_q <= `ACP_S_FIELD;
                        end else if (tgt == `ACP_BCAST_CHAN) begin
                            cmd_chan_out <= `ACP_FIRST_CHAN;
                            last_q <= (`ACP_FIRST_CHAN == `ACP_NCH_W);
                            state_q <= `ACP_S_DISP;
                        end else if (tgt <= `ACP_NCH_W) begin
                            cmd_chan_out <= tgt;
                            last_q <= 1'b1;
                            state_q <= `ACP_S_DISP;
                        end else begin
                            // A channel that is not installed gets a bare return.
                            pend_q <= 1'b1;
                            pchar_q <= `ACP_CR;
                        end
                    end else if (rx_take) begin
                        case (ph_q)
                            `ACP_PH_CHAN: begin
                                if (is_dig) begin
                                    chan_acc_q <= chan_nx;
                                    chan_seen_q <= 1'b1;
                                end else begin
                                    cmd_letter_out <= rx_data_in;
                                    cmd_nargs_out <= 2'h0;
                                    ph_q <= `ACP_PH_WAIT;
                                end
                            end
                            `ACP_PH_WAIT: begin
                                if (is_dig) begin
                                    cmd_arg1_out <= {12'h000, dval};
                                    cmd_nargs_out <= 2'h1;
                                    aidx_q <= 2'h0;
                                    ph_q <= `ACP_PH_ARG;
                                end
                            end
                            default: begin
                                if (is_dig) begin
                                    case (aidx_q)
                                        2'h0: cmd_arg1_out <= arg_nx;
                                        2'h1: cmd_arg2_out <= arg_nx;
                                        default: cmd_arg3_out <= arg_nx;
                                    endcase
                                end else if (rx_data_in == `ACP_COMMA && aidx_q != `ACP_ARG_LAST) begin
                                    // A comma after the third argument is ignored, so any further digits run on into the third.
                                    aidx_q <= aidx_q + 2'h1;
                                    cmd_nargs_out <= cmd_nargs_out + 2'h1;
                                    if (aidx_q == 2'h0) begin
                                        cmd_arg2_out <= 16'h0000;
                                    end else begin
                                        cmd_arg3_out <= 16'h0000;
                                    end
                                end
                            end
                        endcase
                    end
                end
                `ACP_S_DISP: begin
                    // The channel sees the strobe for one cycle and decides which arguments it needs.
                    state_q <= `ACP_S_WAIT;
                end
                `ACP_S_WAIT: begin
                    if (resp_valid_in) begin
                        rv_q[0] <= resp_val1_in;
                        rv_q[1] <= resp_val2_in;
                        rv_q[2] <= resp_val3_in;
                        rcnt_q <= resp_count_in;
                        rflt_q <= fault_active_out[ci];
                        rfno_q <= fno_q[ci];
                        if (clr_ev) begin
                            // The clear reports the error it removed as the first value.
                            rv_q[0] <= {8'h00, fno_q[ci]};
                            rflt_q <= 1'b0;
                            if (resp_count_in == 2'h0) begin
                                rcnt_q <= 2'h1;
                            end
                        end
                        f_q <= `ACP_F_CHAN;
                        state_q <= `ACP_S_FIELD;
                    end
                end
                `ACP_S_FIELD: begin
                    if (!pend_q) begin
                        case (f_q)
                            `ACP_F_CHAN: begin
                                if (verbose_out || cfg_q) begin
                                    num_q <= {8'h00, (cfg_q ? `ACP_CFG_CHAN : cmd_chan_out)};
                                    pw_q <= 3'h0;
                                    nz_q <= 1'b0;
                                    state_q <= `ACP_S_NUM;
                                end else begin
                                    f_q <= `ACP_F_FLT;
                                end
                            end
                            `ACP_F_LET: begin
                                pend_q <= 1'b1;
                                pchar_q <= cmd_letter_out;
                                f_q <= `ACP_F_V1;
                            end
                            `ACP_F_V1, `ACP_F_V2, `ACP_F_V3: begin
                                if (fk < ceff) begin
                                    if (fk != 2'h0) begin
                                        pend_q <= 1'b1;
                                        pchar_q <= `ACP_COMMA;
                                    end
                                    num_q <= rv_q[fk];
                                    pw_q <= 3'h0;
                                    nz_q <= 1'b0;
                                    state_q <= `ACP_S_NUM;
                                end else begin
                                    f_q <= `ACP_F_FLT;
                                end
                            end
                            `ACP_F_FLT: begin
                                if (rflt_q) begin
                                    pend_q <= 1'b1;
                                    pchar_q <= `ACP_STAR;
                                    num_q <= {8'h00, rfno_q};
                                    pw_q <= 3'h0;
                                    nz_q <= 1'b0;
                                    state_q <= `ACP_S_NUM;
                                end else begin
                                    f_q <= `ACP_F_TERM;
                                end
                            end
                            default: begin
                                pend_q <= 1'b1;
                                if (last_q) begin
                                    pchar_q <= `ACP_CR;
                                    state_q <= `ACP_S_PARSE;
                                end else begin
                                    pchar_q <= `ACP_SEMI;
                                    cmd_chan_out <= cmd_chan_out + 8'h01;
                                    last_q <= (cmd_chan_out + 8'h01 == `ACP_NCH_W);
                                    state_q <= `ACP_S_DISP;
                                end
                            end
                        endcase
                    end
                end
                `ACP_S_NUM: begin
                    // Repeated subtraction: slow, but it needs no divider.
                    if (!pend_q) begin
                        if (num_q >= pow) begin
                            num_q <= num_q - pow;
                            dig_q <= dig_q + 4'h1;
                        end else begin
                            if (dig_q != 4'h0 || nz_q || pw_q == `ACP_PW_LAST) begin
                                pend_q <= 1'b1;
                                pchar_q <= `ACP_ZERO + {4'h0, dig_q};
                                nz_q <= 1'b1;
                            end
                            dig_q <= 4'h0;
                            if (pw_q == `ACP_PW_LAST) begin
                                f_q <= f_q + 3'h1;
                                state_q <= `ACP_S_FIELD;
                            end else begin
                                pw_q <= pw_q + 3'h1;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= `ACP_S_PARSE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer: the host side may stall without losing a character.

    acp_buf2 u_txbuf (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .in_valid_in(pend_q),
        .in_ready_out(buf_ready),
        .in_data_in(pchar_q),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(tx_data_out)
    );

endmodule // acp_parser

// >>> verif/acp_parser_sva.sv
/* Port checker for the command parser.
   Assumes one clock and the asynchronous active-low reset of the parser. */
`timescale 1ns/1ns
`include "acp_consts.vh"
module acp_parser_sva (
    input wire mclk_in,
    input wire resetn_in,
    input wire rx_valid_in,
    input wire [`ACP_BYTE_W-1:0] rx_data_in,
    input wire rx_ready_out,
    input wire tx_valid_out,
    input wire [`ACP_BYTE_W-1:0] tx_data_out,
    input wire tx_ready_in,
    input wire cmd_valid_out,
    input wire [`ACP_BYTE_W-1:0] cmd_chan_out,
    input wire [`ACP_BYTE_W-1:0] cmd_letter_out,
    input wire [`ACP_NCH-1:0] fault_set_in,
    input wire [`ACP_NCH-1:0] fault_active_out,
    input wire verbose_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (!resetn_in);
// Accepted bytes, split into the terminator and everything else.
sequence s_cr_in; rx_valid_in && rx_ready_out && rx_data_in == `ACP_CR; endsequence
sequence s_char_in; rx_valid_in && rx_ready_out && rx_data_in != `ACP_CR; endsequence
property p_cr_ends; s_cr_in |=> !rx_ready_out; endproperty
a_cr_ends: assert property (p_cr_ends) else $error("Input still open after terminator.");
property p_no_echo; s_char_in |=> !$rose(tx_valid_out); endproperty
a_no_echo: assert property (p_no_echo) else $error("Output started while a command was typed.");
property p_chan_ok; cmd_valid_out |-> cmd_chan_out >= `ACP_FIRST_CHAN && cmd_chan_out <= `ACP_NCH_W; endproperty
a_chan_ok: assert property (p_chan_ok) else $error("Dispatch to a channel not installed.");
property p_pulse; cmd_valid_out |=> !cmd_valid_out [*2]; endproperty
a_pulse: assert property (p_pulse) else $error("Dispatch pulse too long.");
property p_fault_set; fault_set_in[0] |=> fault_active_out[0]; endproperty
a_fault_set: assert property (p_fault_set) else $error("Fault not latched.");
property p_fault_keep; $fell(fault_active_out[0]) |-> cmd_letter_out == `ACP_LET_C; endproperty
a_fault_keep: assert property (p_fault_keep) else $error("Fault dropped without clear.");
property p_star; tx_valid_out && tx_data_out == `ACP_STAR |-> fault_active_out != 2'h0; endproperty
a_star: assert property (p_star) else $error("Fault marker without a fault.");
property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
a_hold: assert property (p_hold) else $error("Output character lost in stall.");
property p_mode; s_char_in |=> $stable(verbose_out); endproperty
a_mode: assert property (p_mode) else $error("Mode changed before command end.");
endmodule // acp_parser_sva
bind acp_parser acp_parser_sva u_sva (.mclk_in(mclk_in), .resetn_in(resetn_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .tx_ready_in(tx_ready_in), .cmd_valid_out(cmd_valid_out), .cmd_chan_out(cmd_chan_out),
    .cmd_letter_out(cmd_letter_out), .fault_set_in(fault_set_in), .fault_active_out(fault_active_out),
    .verbose_out(verbose_out));

// >>> verif/acp_chan_model.sv
/* Channel answer model: echoes the dispatched arguments as values.
   Assumes the parser's clock and reset. */
`timescale 1ns/1ns
`include "acp_consts.vh"
module acp_chan_model (
    input wire mclk_in,
    input wire resetn_in,
    input wire cmd_valid_in,
    input wire [7:0] letter_in,
    input wire [1:0] nargs_in,
    input wire [15:0] arg1_in,
    input wire [15:0] arg2_in,
    input wire [15:0] arg3_in,
    input wire slow_in,
    output reg resp_valid_out,
    output reg [1:0] resp_count_out,
    output wire [15:0] val1_out,
    output wire [15:0] val2_out,
    output wire [15:0] val3_out
);
reg [3:0] wait_q;
// Answer after one or eight cycles; the slow case probes the parser's wait.
always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        wait_q <= 4'h0;
        resp_valid_out <= 1'b0;
        resp_count_out <= 2'h0;
    end else begin
        resp_valid_out <= wait_q == 4'h1;
        if (cmd_valid_in) begin
            wait_q <= slow_in ? 4'h8 : 4'h1;
            resp_count_out <= letter_in == `ACP_LET_C ? 2'h1 : nargs_in;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
    end
end
// Values are inverted outside the answer so stale data cannot pass.
assign val1_out = resp_valid_out ? arg1_in : ~arg1_in;
assign val2_out = resp_valid_out ? arg2_in : ~arg2_in;
assign val3_out = resp_valid_out ? arg3_in : ~arg3_in;
endmodule // acp_chan_model

// >>> verif/ascii_channel_command_parser_test.sv
/* Self-checking bench for the command parser.
   Assumes the channel model answers every dispatch. */
`timescale 1ns/1ns
module ascii_channel_command_parser_test;
reg mclk_in = 1'b0;
reg resetn_in = 1'b0;
reg rx_valid_in = 1'b0;
reg [7:0] rx_data_in = 8'h00;
reg tx_ready_in = 1'b0;
reg [1:0] fault_set_in = 2'h0;
reg [15:0] fault_no_in = 16'h0000;
reg slow = 1'b0;
wire rx_ready_out, tx_valid_out, cmd_valid_out, resp_valid_in, verbose_out;
wire [7:0] tx_data_out, cmd_chan_out, cmd_letter_out;
wire [15:0] cmd_arg1_out, cmd_arg2_out, cmd_arg3_out, resp_val1_in, resp_val2_in, resp_val3_in;
wire [1:0] cmd_nargs_out, resp_count_in, fault_active_out;
int mismatches = 0;
int check_count = 0;
string rows [10][2] = '{'{"1b\015", "1b\015"}, '{"2v89\015", "2v89\015"}, '{"v7\015", "2v7\015"},
    '{"1r5x,6;,7\015", "1r5,6,7\015"}, '{"0f\015", "1f;2f\015"}, '{"m2\015", "1m2;2m2\015"}, '{"5b\015", "\015"},
    '{"99h0\015", "99h0\015"}, '{"1b\015", "\015"}, '{"99h3\015", "99h1\015"}};
////////////////////////////////////////////////////////////////////////////////
// Clock at 20 MHz.
always #25 mclk_in = ~mclk_in;
acp_parser u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
    .cmd_valid_out(cmd_valid_out), .cmd_chan_out(cmd_chan_out), .cmd_letter_out(cmd_letter_out),
    .cmd_arg1_out(cmd_arg1_out), .cmd_arg2_out(cmd_arg2_out), .cmd_arg3_out(cmd_arg3_out),
    .cmd_nargs_out(cmd_nargs_out), .resp_valid_in(resp_valid_in), .resp_count_in(resp_count_in),
    .resp_val1_in(resp_val1_in), .resp_val2_in(resp_val2_in), .resp_val3_in(resp_val3_in),
    .fault_set_in(fault_set_in), .fault_no_in(fault_no_in), .fault_active_out(fault_active_out),
    .verbose_out(verbose_out));
acp_chan_model u_chan (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_out),
    .letter_in(cmd_letter_out), .nargs_in(cmd_nargs_out), .arg1_in(cmd_arg1_out), .arg2_in(cmd_arg2_out),
    .arg3_in(cmd_arg3_out), .slow_in(slow), .resp_valid_out(resp_valid_in), .resp_count_out(resp_count_in),
    .val1_out(resp_val1_in), .val2_out(resp_val2_in), .val3_out(resp_val3_in));
////////////////////////////////////////////////////////////////////////////////
// Compare one value and count it.
task automatic chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp) begin
        mismatches++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// Print the verdict and stop.
task automatic final_report;
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
// Send one command, then collect the answer; the host never types ahead of it.
task automatic run(input string c, input string r, input int stall);
    string got;
    int k;
    got = "";
    k = 0;
    for (int i = 0; i < c.len(); i++) begin
        rx_valid_in = 1'b1;
        rx_data_in = c[i];
        do @(negedge mclk_in); while (rx_ready_out !== 1'b1);
        @(posedge mclk_in);
        #2;
    end
    rx_valid_in = 1'b0;
    while (1) begin
        @(negedge mclk_in);
        if (tx_valid_out === 1'b1 && tx_ready_in) begin
            got = {got, string'(tx_data_out)};
            if (tx_data_out == 8'h0d) break;
        end
        @(posedge mclk_in);
        #2;
        k++;
        tx_ready_in = (k > stall) && k[0];
    end
    @(posedge mclk_in);
    #2;
    tx_ready_in = 1'b0;
    for (int i = 0; i < r.len() || i < got.len(); i++) chk(got[i], r[i]);
endtask
////////////////////////////////////////////////////////////////////////////////
// Table of commands first, then faults and a long output stall.
initial begin
    repeat (16) @(posedge mclk_in);
    chk(verbose_out, 1);
    chk(fault_active_out, 0);
    chk(tx_valid_out, 0);
    #2 resetn_in = 1'b1;
    for (int i = 0; i < 10; i++) begin
        slow = i[0];
        run(rows[i][0], rows[i][1], 0);
    end
    fault_no_in = 16'h0007;
    fault_set_in = 2'h1;
    @(posedge mclk_in);
    #2 fault_set_in = 2'h0;
    chk(fault_active_out, 2'h1);
    run("1r5,6,7\015", "1r5,6*7\015", 40);
    run("0b\015", "1b*7;2b\015", 0);
    run("1c\015", "1c7\015", 0);
    chk(fault_active_out, 2'h0);
    run("1b\015", "1b\015", 0);
    final_report;
end
// Watchdog: far beyond the few hundred cycles the run needs.
initial begin
    #4000000;
    mismatches++;
    final_report;
end
endmodule // ascii_channel_command_parser_test
